// ### pkg/drive_fault_pkg.sv
// shared types and constants of the drive fault supervisor
// assumes measurements arrive as unsigned converter counts, synchronous to sys_clk_i
package drive_fault_pkg;

    // measurement widths in converter counts
    localparam int CUR_W = 12;
    localparam int VOLT_W = 12;
    localparam int TEMP_W = 10;
    localparam int SPD_W = 16;
    localparam int SQ_W = 2 * CUR_W;
    localparam int EST_W = 32;

    // limit defaults applied when logic power comes up
    localparam logic [CUR_W-1:0] PEAK_CURRENT_DEFAULT = 12'h640;
    // over-current sits at 1.25 times peak current
    localparam logic [CUR_W-1:0] OC_LIMIT_DEFAULT = PEAK_CURRENT_DEFAULT + (PEAK_CURRENT_DEFAULT >> 2);
    localparam logic [VOLT_W-1:0] MOTOR_OV_DEFAULT = 12'hD00;
    localparam logic [VOLT_W-1:0] MODULE_OV_DEFAULT = 12'hE00;
    localparam logic [VOLT_W-1:0] UV_LIMIT_DEFAULT = 12'h100;
    localparam logic [TEMP_W-1:0] TEMP_WARN_DEFAULT = 10'h300;
    localparam logic [TEMP_W-1:0] TEMP_CRIT_DEFAULT = 10'h380;
    localparam logic [SPD_W-1:0] SPEED_LIMIT_DEFAULT = 16'hF000;
    localparam logic [CUR_W-1:0] HEAT_CONT_DEFAULT = 12'h400;
    localparam logic [EST_W-1:0] HEAT_LIMIT_DEFAULT = 32'h0100_0000;
    // absolute maximum bus rating, fixed and not configurable
    localparam logic [VOLT_W-1:0] BUS_ABS_MAX = 12'hF00;

    // raw monitor inputs
    typedef struct packed {
        logic [CUR_W-1:0] phase_a;
        logic [CUR_W-1:0] phase_b;
        logic [CUR_W-1:0] phase_c;
        logic [VOLT_W-1:0] dc_bus_voltage;
        logic [TEMP_W-1:0] proc_temp;
        logic [TEMP_W-1:0] stage_temp;
        logic [SPD_W-1:0] motor_speed;
        logic motor_therm_hot;
        logic feedback_ok;
        logic self_test_fail;
    } meas_t;

    // configurable thresholds
    typedef struct packed {
        logic [CUR_W-1:0] oc_limit;
        logic [VOLT_W-1:0] motor_ov_limit;
        logic [VOLT_W-1:0] module_ov_limit;
        logic [VOLT_W-1:0] uv_limit;
        logic [TEMP_W-1:0] temp_warn;
        logic [TEMP_W-1:0] temp_crit;
        logic [SPD_W-1:0] speed_limit;
        logic [CUR_W-1:0] heat_cont;
        logic [EST_W-1:0] heat_limit;
    } limits_t;

    localparam limits_t LIMITS_DEFAULT = '{OC_LIMIT_DEFAULT, MOTOR_OV_DEFAULT,
        MODULE_OV_DEFAULT, UV_LIMIT_DEFAULT, TEMP_WARN_DEFAULT, TEMP_CRIT_DEFAULT,
        SPEED_LIMIT_DEFAULT, HEAT_CONT_DEFAULT, HEAT_LIMIT_DEFAULT};

    // one flag per fault cause
    typedef struct packed {
        logic over_current;
        logic over_voltage;
        logic bus_abs_max;
        logic proc_over_temp;
        logic stage_over_temp;
        logic self_test;
        logic motor_over_temp;
        logic over_speed;
        logic under_voltage;
        logic feedback_loss;
        logic heat_trip;
    } faults_t;

    typedef enum logic [2:0] {
        ST_DISABLED = 3'b001,
        ST_ENABLED = 3'b010,
        ST_FAULTED = 3'b100
    } drive_state_t;

endpackage : drive_fault_pkg

// ### hw/current_squared_time.sv
// current-squared-time estimator of motor heating
// assumes phase currents are magnitudes sampled once per clock
`timescale 1ns/10ps
module current_squared_time
    import drive_fault_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // inputs
    input wire logic [drive_fault_pkg::CUR_W-1:0] peak_current_i,
    input wire logic [drive_fault_pkg::CUR_W-1:0] cont_current_i,
    input wire logic [drive_fault_pkg::EST_W-1:0] trip_limit_i,
    // outputs
    output logic [drive_fault_pkg::EST_W-1:0] current_squared_time_estimate_o,
    output logic trip_o
);
    logic [SQ_W-1:0] peak_sq;
    logic [SQ_W-1:0] cont_sq;
    logic [EST_W:0] wide_sum;
    logic [EST_W-1:0] next_estimate;
    logic next_trip;

    // heat grows with the square above the continuous rating, cools below it
    always_comb
    begin
        // widen before multiplying so the square is never cut to the operand width
        peak_sq = SQ_W'(peak_current_i) * SQ_W'(peak_current_i);
        cont_sq = SQ_W'(cont_current_i) * SQ_W'(cont_current_i);
        wide_sum = '0;
        if (peak_sq >= cont_sq)
        begin
            wide_sum = {1'b0, current_squared_time_estimate_o} + (EST_W+1)'(peak_sq - cont_sq);
            // saturate so a long overload never wraps back to cool
            next_estimate = wide_sum[EST_W] ? '1 : wide_sum[EST_W-1:0];
        end
        else if (current_squared_time_estimate_o > EST_W'(cont_sq - peak_sq))
        begin
            next_estimate = current_squared_time_estimate_o - EST_W'(cont_sq - peak_sq);
        end
        else
        begin
            next_estimate = '0;
        end
        next_trip = next_estimate > trip_limit_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            current_squared_time_estimate_o <= '0;
            trip_o <= 1'b0;
        end
        else
        begin
            current_squared_time_estimate_o <= next_estimate;
            trip_o <= next_trip;
        end
    end

    // the trip was judged against the limit in force at the edge that raised it
    property p_heat_trip;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        trip_o |-> current_squared_time_estimate_o > $past(trip_limit_i);
    endproperty
    a_heat_trip: assert property (p_heat_trip) else $error("estimate trip without crossing");

endmodule : current_squared_time

// ### hw/drive_fault_supervisor.sv
// fault-protection supervisor: latches faults and gates the drive enable
// assumes monitor inputs and host command pulses are synchronous to sys_clk_i
// Functional notes
// - over-current on any phase disables drive
// - re-enable only after cause gone and cleared
// - bus above lower over-voltage limit disables
// - near-critical temperature raises warning only
// - critical temperature shuts down, latches fault
// - test, thermistor, speed, undervoltage, feedback faults
// - current-squared-time estimate over limit trips
// - bus above absolute maximum flags fault
// - power-up loads configuration, limits at default
// - stay disabled until enable with no fault
`timescale 1ns/10ps
module drive_fault_supervisor
    import drive_fault_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // monitor inputs
    input drive_fault_pkg::meas_t meas_i,
    // stored configuration
    input drive_fault_pkg::limits_t cfg_i,
    input wire logic cfg_load_i,
    // host commands
    input wire logic enable_cmd_i,
    input wire logic disable_cmd_i,
    input wire logic reset_cmd_i,
    // status
    output drive_fault_pkg::faults_t fault_flags_o,
    output logic warn_temp_o,
    output logic fault_active_o,
    output logic drive_enable_o
);
    import drive_fault_pkg::*;

    function automatic logic [CUR_W-1:0] max3(input logic [CUR_W-1:0] a,
        input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
        logic [CUR_W-1:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction : max3

    function automatic logic in_warn_band(input logic [TEMP_W-1:0] t,
        input logic [TEMP_W-1:0] warn, input logic [TEMP_W-1:0] crit);
        return (t >= warn) && (t < crit);
    endfunction : in_warn_band

    limits_t limits;
    limits_t next_limits;
    faults_t cause;
    faults_t next_flags;
    drive_state_t state;
    drive_state_t next_state;
    logic next_warn;
    logic next_active;
    logic next_enable;
    logic [CUR_W-1:0] peak_current;
    logic [VOLT_W-1:0] ov_limit;
    logic heat_trip;

    assign peak_current = max3(meas_i.phase_a, meas_i.phase_b, meas_i.phase_c);
    // the tighter of the two over-voltage limits governs
    assign ov_limit = (limits.motor_ov_limit < limits.module_ov_limit) ?
        limits.motor_ov_limit : limits.module_ov_limit;

    current_squared_time u_heat (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .peak_current_i(peak_current),
        .cont_current_i(limits.heat_cont),
        .trip_limit_i(limits.heat_limit),
        .current_squared_time_estimate_o(),
        .trip_o(heat_trip)
    );

    // limits: defaults at power-up, reloaded only while the drive is off
    always_comb
    begin
        next_limits = limits;
        if (cfg_load_i && (state != ST_ENABLED))
        begin
            next_limits = cfg_i;
        end
    end

    // present fault causes, evaluated every cycle
    always_comb
    begin
        cause = '0;
        cause.over_current = peak_current > limits.oc_limit;
        cause.over_voltage = meas_i.dc_bus_voltage > ov_limit;
        cause.bus_abs_max = meas_i.dc_bus_voltage > BUS_ABS_MAX;
        cause.proc_over_temp = meas_i.proc_temp >= limits.temp_crit;
        cause.stage_over_temp = meas_i.stage_temp >= limits.temp_crit;
        cause.self_test = meas_i.self_test_fail;
        cause.motor_over_temp = meas_i.motor_therm_hot;
        cause.over_speed = meas_i.motor_speed > limits.speed_limit;
        cause.under_voltage = meas_i.dc_bus_voltage < limits.uv_limit;
        cause.feedback_loss = !meas_i.feedback_ok;
        cause.heat_trip = heat_trip;
    end

    // latch and state: a present cause always wins over a reset command
    always_comb
    begin
        next_flags = cause | (fault_flags_o & ~(reset_cmd_i ? '1 : faults_t'('0)));
        next_active = |next_flags;
        next_warn = in_warn_band(meas_i.proc_temp, limits.temp_warn, limits.temp_crit)
            || in_warn_band(meas_i.stage_temp, limits.temp_warn, limits.temp_crit);
        next_state = state;
        case (state)
            ST_DISABLED:
            begin
                if (enable_cmd_i && !next_active)
                begin
                    next_state = ST_ENABLED;
                end
            end
            ST_ENABLED:
            begin
                if (|cause)
                begin
                    next_state = ST_FAULTED;
                end
                else if (disable_cmd_i)
                begin
                    next_state = ST_DISABLED;
                end
            end
            ST_FAULTED:
            begin
                // an enable here is ignored: reset must come first
                if (!next_active)
                begin
                    next_state = ST_DISABLED;
                end
            end
            default:
            begin
                next_state = ST_DISABLED;
            end
        endcase
        next_enable = (next_state == ST_ENABLED);
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            limits <= LIMITS_DEFAULT;
            state <= ST_DISABLED;
            fault_flags_o <= '0;
            fault_active_o <= 1'b0;
            warn_temp_o <= 1'b0;
            drive_enable_o <= 1'b0;
        end
        else
        begin
            limits <= next_limits;
            state <= next_state;
            fault_flags_o <= next_flags;
            fault_active_o <= next_active;
            warn_temp_o <= next_warn;
            drive_enable_o <= next_enable;
        end
    end

    property p_over_current;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (peak_current > limits.oc_limit) |=> fault_flags_o.over_current && !drive_enable_o;
    endproperty
    a_over_current: assert property (p_over_current) else $error("over-current not latched");

    property p_hold_until_reset;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (fault_active_o && !reset_cmd_i) |=> fault_active_o ##0 !drive_enable_o;
    endproperty
    a_hold_until_reset: assert property (p_hold_until_reset) else $error("fault cleared early");

    property p_over_voltage;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (meas_i.dc_bus_voltage > limits.motor_ov_limit
            || meas_i.dc_bus_voltage > limits.module_ov_limit)
        |=> fault_flags_o.over_voltage && !drive_enable_o;
    endproperty
    a_over_voltage: assert property (p_over_voltage) else $error("over-voltage missed");

    property p_warn_only;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (meas_i.proc_temp >= limits.temp_warn && meas_i.proc_temp < limits.temp_crit)
        |=> warn_temp_o && (!fault_flags_o.proc_over_temp || $past(fault_flags_o.proc_over_temp));
    endproperty
    a_warn_only: assert property (p_warn_only) else $error("warning band wrong");

    property p_critical_temp;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (meas_i.stage_temp >= limits.temp_crit) |=> fault_flags_o.stage_over_temp
            && !drive_enable_o;
    endproperty
    a_critical_temp: assert property (p_critical_temp) else $error("critical temp missed");

    property p_feedback_loss;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !meas_i.feedback_ok |=> fault_flags_o.feedback_loss && fault_active_o;
    endproperty
    a_feedback_loss: assert property (p_feedback_loss) else $error("feedback loss missed");

    property p_heat_latch;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        heat_trip |=> fault_flags_o.heat_trip;
    endproperty
    a_heat_latch: assert property (p_heat_latch) else $error("estimate trip not latched");

    property p_abs_max;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (meas_i.dc_bus_voltage > BUS_ABS_MAX) |=> fault_flags_o.bus_abs_max && !drive_enable_o;
    endproperty
    a_abs_max: assert property (p_abs_max) else $error("absolute bus maximum missed");

    property p_cfg_load;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (cfg_load_i && state != ST_ENABLED) |=> limits == $past(cfg_i);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("configuration not loaded");

    property p_enable_cause;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(drive_enable_o) |-> $past(enable_cmd_i) && fault_flags_o == '0;
    endproperty
    a_enable_cause: assert property (p_enable_cause) else $error("enable without command");

    c_enable: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(drive_enable_o));
    c_trip: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        drive_enable_o ##1 fault_active_o);
    c_recover: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        fault_active_o ##1 !fault_active_o ##[1:20] drive_enable_o);
    c_warn: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) warn_temp_o && drive_enable_o);

endmodule : drive_fault_supervisor

// ### verification/host_cmd_model.sv
// host controller model issuing enable, disable and fault-reset commands
// assumes the sequence hands it one-cycle request levels on sys_clk_i
`timescale 1ns/10ps
module host_cmd_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // requests from the sequence
    input wire logic want_enable_i,
    input wire logic want_disable_i,
    input wire logic want_reset_i,
    input wire logic misbehave_i,
    // drive status
    input wire logic fault_active_i,
    // command pulses
    output logic enable_cmd_o,
    output logic disable_cmd_o,
    output logic reset_cmd_o
);
    // registered, so every command changes just after an edge and lasts as long as its request
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            enable_cmd_o <= 1'b0;
            disable_cmd_o <= 1'b0;
            reset_cmd_o <= 1'b0;
        end
        else
        begin
            // a polite host never enables over an active fault; misbehave overrides
            enable_cmd_o <= want_enable_i & (misbehave_i | ~fault_active_i);
            disable_cmd_o <= want_disable_i;
            reset_cmd_o <= want_reset_i;
        end
    end
endmodule : host_cmd_model

// ### verification/drive_fault_supervisor_bench.sv
// self-checking bench: reference model compared with the supervisor every cycle
// assumes host_cmd_model and the design package are compiled first
`timescale 1ns/10ps
module drive_fault_supervisor_bench;
    import drive_fault_pkg::*;
    localparam meas_t SAFE = '{12'h100, 12'h100, 12'h100, 12'h800, 10'h100, 10'h100,
        16'h1000, 1'b0, 1'b1, 1'b0};
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    meas_t meas = SAFE;
    meas_t rnd_meas;
    limits_t cfg = LIMITS_DEFAULT;
    logic cfg_load = 1'b0;
    logic req_en = 1'b0;
    logic req_dis = 1'b0;
    logic req_rst = 1'b0;
    logic rude = 1'b0;
    logic en_cmd, dis_cmd, rst_cmd, warn, active, drive;
    faults_t flags;
    logic [31:0] r;
    int err_total = 0;
    int n_checks = 0;
    int seed = 78381;
    // reference state
    faults_t exp_flags = '0;
    logic exp_warn = 1'b0;
    int exp_st = 0;
    longint est = 0;
    limits_t lim = LIMITS_DEFAULT;

    drive_fault_supervisor DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .meas_i(meas),
        .cfg_i(cfg), .cfg_load_i(cfg_load), .enable_cmd_i(en_cmd), .disable_cmd_i(dis_cmd),
        .reset_cmd_i(rst_cmd), .fault_flags_o(flags), .warn_temp_o(warn),
        .fault_active_o(active), .drive_enable_o(drive));
    host_cmd_model host_side (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .want_enable_i(req_en),
        .want_disable_i(req_dis), .want_reset_i(req_rst), .misbehave_i(rude),
        .fault_active_i(active), .enable_cmd_o(en_cmd), .disable_cmd_o(dis_cmd),
        .reset_cmd_o(rst_cmd));

    initial
    begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // reference model; state 0 disabled, 1 enabled, 2 faulted
    always @(posedge sys_clk_i or negedge nrst_i)
    begin : ref_model
        faults_t c, nf;
        int mx;
        if (!nrst_i)
        begin
            exp_flags = '0;
            exp_warn = 1'b0;
            exp_st = 0;
            est = 0;
            lim = LIMITS_DEFAULT;
        end
        else
        begin
            mx = int'(meas.phase_a);
            if (int'(meas.phase_b) > mx) mx = int'(meas.phase_b);
            if (int'(meas.phase_c) > mx) mx = int'(meas.phase_c);
            c = '0;
            c.over_current = mx > int'(lim.oc_limit);
            c.over_voltage = meas.dc_bus_voltage > ((lim.motor_ov_limit < lim.module_ov_limit)
                ? lim.motor_ov_limit : lim.module_ov_limit);
            c.bus_abs_max = meas.dc_bus_voltage > BUS_ABS_MAX;
            c.proc_over_temp = meas.proc_temp >= lim.temp_crit;
            c.stage_over_temp = meas.stage_temp >= lim.temp_crit;
            c.self_test = meas.self_test_fail;
            c.motor_over_temp = meas.motor_therm_hot;
            c.over_speed = meas.motor_speed > lim.speed_limit;
            c.under_voltage = meas.dc_bus_voltage < lim.uv_limit;
            c.feedback_loss = !meas.feedback_ok;
            c.heat_trip = est > longint'(lim.heat_limit);
            est = est + mx * mx - int'(lim.heat_cont) * int'(lim.heat_cont);
            if (est < 0) est = 0;
            nf = c | (exp_flags & ~{11{rst_cmd}});
            exp_warn = (meas.proc_temp >= lim.temp_warn && meas.proc_temp < lim.temp_crit)
                || (meas.stage_temp >= lim.temp_warn && meas.stage_temp < lim.temp_crit);
            // the load is judged on the state before this edge
            if (cfg_load && exp_st != 1) lim = cfg;
            // a fault raised while disabled latches but leaves the state alone
            case (exp_st)
                0:
                    if (en_cmd && nf == '0)
                        exp_st = 1;
                1:
                    if (|c)
                        exp_st = 2;
                    else if (dis_cmd)
                        exp_st = 0;
                default:
                    if (nf == '0)
                        exp_st = 0;
            endcase
            exp_flags = nf;
        end
    end

    task automatic check_flags(input faults_t e, input faults_t g);
        n_checks++;
        if (e !== g)
        begin
            err_total++;
            $display("mismatch fault_flags expected %h seen %h", e, g);
        end
    endtask : check_flags

    task automatic check_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (e !== g)
        begin
            err_total++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : check_bit

    // compare on the falling edge, where every output has settled
    always @(negedge sys_clk_i)
    begin
        check_flags(exp_flags, flags);
        check_bit("warn_temp", exp_warn, warn);
        check_bit("fault_active", |exp_flags, active);
        check_bit("drive_enable", exp_st == 1, drive);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    task automatic host(input int kind, input logic bad);
        @(posedge sys_clk_i);
        rude <= bad;
        case (kind)
            0: req_en <= 1'b1;
            1: req_dis <= 1'b1;
            default: req_rst <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        {req_en, req_dis, req_rst, rude} <= '0;
        tick(2);
    endtask : host

    // resolve, clear, then enable again; the wait drains the heating estimate
    task automatic recover;
        @(posedge sys_clk_i);
        meas <= SAFE;
        tick(60);
        host(2, 1'b0);
        host(0, 1'b0);
    endtask : recover

    task automatic pulse_load;
        @(posedge sys_clk_i);
        cfg_load <= 1'b1;
        @(posedge sys_clk_i);
        cfg_load <= 1'b0;
    endtask : pulse_load

    // hit 0 is the last harmless boundary value, hit 1 the first that trips; in case 2 hit 0 already trips over_voltage, in case 0 heat_trip
    task automatic apply(input int k, input logic hit);
        meas_t m;
        m = SAFE;
        case (k)
            0: m.phase_b = OC_LIMIT_DEFAULT + 12'(hit);
            1: m.dc_bus_voltage = MOTOR_OV_DEFAULT + 12'(hit);
            2: m.dc_bus_voltage = BUS_ABS_MAX + 12'(hit);
            3: m.proc_temp = TEMP_CRIT_DEFAULT - 10'(!hit);
            4: m.stage_temp = TEMP_CRIT_DEFAULT - 10'(!hit);
            5: m.self_test_fail = hit;
            6: m.motor_therm_hot = hit;
            7: m.motor_speed = SPEED_LIMIT_DEFAULT + 16'(hit);
            8: m.dc_bus_voltage = UV_LIMIT_DEFAULT - 12'(hit);
            9: m.feedback_ok = !hit;
            default: m.phase_a = hit ? OC_LIMIT_DEFAULT : HEAT_CONT_DEFAULT;
        endcase
        @(posedge sys_clk_i);
        meas <= m;
        tick(10);
    endtask : apply

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #480000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        tick(16);
        nrst_i <= 1'b1;
        tick(2);
        for (int k = 0; k < 11; k++)
        begin
            recover();
            apply(k, 1'b0);
            apply(k, 1'b1);
            host(0, 1'b1);
            host(2, 1'b0);
            @(posedge sys_clk_i);
            meas <= SAFE;
            tick(60);
            host(0, 1'b1);
        end
        // a load while enabled is ignored, the one while disabled lands
        recover();
        @(posedge sys_clk_i);
        cfg.oc_limit <= 12'h200;
        pulse_load();
        meas.phase_a <= 12'h300;
        tick(4);
        host(1, 1'b0);
        pulse_load();
        recover();
        meas.phase_a <= 12'h201;
        tick(4);
        // second reset must bring the default limits back
        nrst_i <= 1'b0;
        tick(3);
        nrst_i <= 1'b1;
        meas <= SAFE;
        recover();
        meas.phase_a <= 12'h300;
        tick(4);
        for (int i = 0; i < 3000; i++)
        begin
            r = $random(seed);
            // build the whole word first so meas is written once per edge
            rnd_meas = SAFE;
            rnd_meas.phase_a = 12'(r[9:0]);
            rnd_meas.proc_temp = 10'h2F0 + 10'(r[13:10] * 8);
            rnd_meas.feedback_ok = (r[20:16] != 5'h00);
            rnd_meas.phase_c = (r[25:21] == 5'h00) ? 12'h7FF : 12'h100;
            meas <= rnd_meas;
            req_dis <= (r[31:28] == 4'h0);
            req_en <= r[26] & (r[31:28] != 4'h0);
            req_rst <= r[27];
            @(posedge sys_clk_i);
        end
        {req_en, req_dis, req_rst} <= '0;
        tick(4);
        tally_and_finish();
    end
endmodule : drive_fault_supervisor_bench
